/* File: common/aps_pkg.sv */
// Constants, types and register map of the absolute position setup block.
package aps_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int APS_AW = 8;
  localparam logic [7:0] OFS_ENC_USAGE = 8'h00;
  localparam logic [7:0] OFS_SCALE_TYPE = 8'h04;
  localparam logic [7:0] OFS_SCALE_DIR = 8'h08;
  localparam logic [7:0] OFS_INDEX_DIS = 8'h0C;
  localparam logic [7:0] OFS_COMM_EXT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_STATE = 8'h20;
  localparam logic [7:0] OFS_SCALE_POS = 8'h24;
  localparam logic [7:0] OFS_MTURN = 8'h28;
  localparam logic [7:0] OFS_MT_LIMIT = 8'h2C;

  // ----------------------------------------------------------------
  // Reset values, fields and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] ENC_USAGE_RST = 16'h0001;
  localparam logic [15:0] MT_LIMIT_RST = 16'hFFFF;
  localparam int EXT_MON_BIT = 4;
  localparam logic [15:0] ENC_USAGE_MAX = 16'h0004;
  localparam logic [15:0] DIR_INVERT = 16'h0001;

  typedef enum logic [2:0] {
    ENC_ABS = 3'h0,
    ENC_INC = 3'h1,
    ENC_ABS_NOOVF = 3'h2,
    ENC_SINGLE = 3'h3,
    ENC_CONT = 3'h4
  } aps_enc_mode_t;

  localparam logic [2:0] SCALE_AB = 3'h0;
  localparam logic [2:0] SCALE_SER_INC = 3'h1;
  localparam logic [2:0] SCALE_SER_ABS = 3'h2;
  localparam logic [2:0] SCALE_SER_ROT = 3'h6;

  // Communication cycles, in microseconds, that forbid monitoring.
  localparam logic [15:0] COMM_CYC_250_US = 16'h00FA;
  localparam logic [15:0] COMM_CYC_125_US = 16'h007D;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Error and event flags, also the interrupt bit layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scale_link;
    logic scale_break;
    logic scale_conn;
    logic cmd;
    logic abs_ospd;
    logic abs_over;
    logic abs_down;
  } aps_err_t;
  localparam int ERR_W = 7;

endpackage : aps_pkg

/* File: src/aps_setup.sv */
// Absolute encoder and external scale setup, supervision and register file.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module aps_setup
  import aps_pkg::*;
#(
  parameter int ST_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite slave.
  input wire logic [APS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [APS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Encoder side.
  input wire logic [ST_W-1:0] enc_single_turn,
  input wire logic enc_turn_up,
  input wire logic enc_turn_down,
  input wire logic enc_batt_fail_pin,
  input wire logic enc_overspeed_pin,
  // External scale side.
  input wire logic scale_cnt_up,
  input wire logic scale_cnt_dn,
  input wire logic scale_present,
  input wire logic [2:0] scale_kind_id,
  input wire logic scale_z_lost_pin,
  input wire logic scale_link_fault_pin,
  // Control loop and fieldbus.
  input wire logic full_closed,
  input wire logic [15:0] comm_cycle_us,
  output logic [31:0] cur_pos,
  output logic [31:0] scale_pos,
  output logic mt_valid,
  output logic scale_mon_en,
  output aps_err_t err_o,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] enc_usage_reg, scale_type_reg, scale_dir_reg;
  logic [15:0] index_dis_reg, comm_ext_reg, mt_limit_reg;
  logic [15:0] mt_reg;
  logic [31:0] scnt_reg;
  logic [ERR_W-1:0] status_reg, enable_reg, clr_mask;
  logic [APS_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [3:0] sync1_reg, sync2_reg;
  logic wr_go, mon_en, mt_ovf, sdir_up;
  aps_enc_mode_t eff;
  aps_err_t ev;
  logic [15:0] wv;

  // Merge a 16-bit register with the written low byte lanes.
  function automatic logic [15:0] merge16(input logic [15:0] o,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Only the second stage is read below.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {scale_link_fault_pin, scale_z_lost_pin,
                    enc_overspeed_pin, enc_batt_fail_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write happens
  // once both are held and no response is pending.
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wv = merge16(16'h0000, wdata_q, wstrb_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_q > OFS_MT_LIMIT || awaddr_q[1:0] != 2'h0) begin
          s_axi_bresp <= RESP_SLVERR;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers; out-of-range usage and scale type values are refused.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_usage_reg <= ENC_USAGE_RST;
      scale_type_reg <= 16'h0000;
      scale_dir_reg <= 16'h0000;
      index_dis_reg <= 16'h0000;
      comm_ext_reg <= 16'h0000;
      mt_limit_reg <= MT_LIMIT_RST;
      enable_reg <= '0;
    end else if (wr_go) begin
      if (awaddr_q == OFS_ENC_USAGE) begin
        if (merge16(enc_usage_reg, wdata_q, wstrb_q) <= ENC_USAGE_MAX) begin
          enc_usage_reg <= merge16(enc_usage_reg, wdata_q,
                                   wstrb_q);
        end
      end else if (awaddr_q == OFS_SCALE_TYPE) begin
        // Reserved codes 3..5 and above 6 are not accepted.
        if (wv <= 16'h0002 || wv == 16'h0006) begin
          scale_type_reg <= wv;
        end
      end else if (awaddr_q == OFS_SCALE_DIR) begin
        scale_dir_reg <= {14'h0000, wv[1:0]};
      end else if (awaddr_q == OFS_INDEX_DIS) begin
        index_dis_reg <= {15'h0000, wv[0]};
      end else if (awaddr_q == OFS_COMM_EXT) begin
        comm_ext_reg <= merge16(comm_ext_reg, wdata_q, wstrb_q);
      end else if (awaddr_q == OFS_IRQ_ENABLE) begin
        enable_reg <= wdata_q[ERR_W-1:0];
      end else if (awaddr_q == OFS_MT_LIMIT) begin
        mt_limit_reg <= merge16(mt_limit_reg, wdata_q, wstrb_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Data is answered one cycle after the address is taken.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == OFS_ENC_USAGE) begin
        s_axi_rdata <= {16'h0000, enc_usage_reg};
      end else if (s_axi_araddr == OFS_SCALE_TYPE) begin
        s_axi_rdata <= {16'h0000, scale_type_reg};
      end else if (s_axi_araddr == OFS_SCALE_DIR) begin
        s_axi_rdata <= {16'h0000, scale_dir_reg};
      end else if (s_axi_araddr == OFS_INDEX_DIS) begin
        s_axi_rdata <= {16'h0000, index_dis_reg};
      end else if (s_axi_araddr == OFS_COMM_EXT) begin
        s_axi_rdata <= {16'h0000, comm_ext_reg};
      end else if (s_axi_araddr == OFS_IRQ_STATUS) begin
        s_axi_rdata <= {25'h0, status_reg};
      end else if (s_axi_araddr == OFS_IRQ_CLEAR) begin
        s_axi_rdata <= 32'h0;
      end else if (s_axi_araddr == OFS_IRQ_ENABLE) begin
        s_axi_rdata <= {25'h0, enable_reg};
      end else if (s_axi_araddr == OFS_STATE) begin
        s_axi_rdata <= {27'h0, mon_en, full_closed, eff};
      end else if (s_axi_araddr == OFS_SCALE_POS) begin
        s_axi_rdata <= scale_pos;
      end else if (s_axi_araddr == OFS_MTURN) begin
        s_axi_rdata <= {16'h0000, mt_reg};
      end else if (s_axi_araddr == OFS_MT_LIMIT) begin
        s_axi_rdata <= {16'h0000, mt_limit_reg};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Effective encoder mode and multi-turn counter
  // ----------------------------------------------------------------
  // Full-closed control overrides the stored setting.
  assign eff = full_closed ? ENC_INC
                           : aps_enc_mode_t'(enc_usage_reg[2:0]);
  // Only plain absolute mode reports an overflow; 2 and 4 wrap quietly.
  assign mt_ovf = (eff == ENC_ABS) && (enc_turn_up != enc_turn_down) &&
                  ((enc_turn_up && mt_reg == 16'hFFFF) ||
                   (enc_turn_down && mt_reg == 16'h0000));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mt_reg <= 16'h0000;
    end else begin
      case (eff)
        ENC_SINGLE: mt_reg <= 16'h0000;
        ENC_CONT: begin
          if (enc_turn_up && !enc_turn_down) begin
            mt_reg <= (mt_reg >= mt_limit_reg) ? 16'h0000
                                               : mt_reg + 16'h0001;
          end else if (enc_turn_down && !enc_turn_up) begin
            mt_reg <= (mt_reg == 16'h0000) ? mt_limit_reg
                                           : mt_reg - 16'h0001;
          end
        end
        default: begin
          if (enc_turn_up && !enc_turn_down) begin
            mt_reg <= mt_reg + 16'h0001;
          end else if (enc_turn_down && !enc_turn_up) begin
            mt_reg <= mt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External scale counter, cleared only by power-on reset
  // ----------------------------------------------------------------
  // Homing has no path to this counter so the position survives it.
  assign mon_en = full_closed || comm_ext_reg[EXT_MON_BIT];
  assign sdir_up = scale_cnt_up ^ (scale_dir_reg == DIR_INVERT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scnt_reg <= 32'h0;
    end else if (scale_cnt_up != scale_cnt_dn) begin
      scnt_reg <= sdir_up ? scnt_reg + 32'h1 : scnt_reg - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Error events and registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    ev.abs_down = sync2_reg[0] && (eff != ENC_INC);
    ev.abs_ospd = sync2_reg[1] && (eff != ENC_INC);
    ev.abs_over = mt_ovf;
    ev.cmd = comm_ext_reg[EXT_MON_BIT] && !full_closed &&
             (comm_cycle_us == COMM_CYC_250_US ||
              comm_cycle_us == COMM_CYC_125_US);
    ev.scale_conn = mon_en && scale_present &&
                    (scale_kind_id != scale_type_reg[2:0]);
    ev.scale_break = mon_en && (scale_type_reg[2:0] == SCALE_AB) &&
                     !index_dis_reg[0] && sync2_reg[2];
    ev.scale_link = mon_en && sync2_reg[3];
  end

  // Write-only clear; a new event in the same cycle wins over it.
  assign clr_mask = (wr_go && awaddr_q == OFS_IRQ_CLEAR) ?
                    wdata_q[ERR_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
      irq <= 1'b0;
      err_o <= '0;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | ev;
      irq <= |(((status_reg & ~clr_mask) | ev) & enable_reg);
      err_o <= ev;
    end
  end

  // Position presented to the fieldbus response each cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_pos <= 32'h0;
      scale_pos <= 32'h0;
      mt_valid <= 1'b0;
      scale_mon_en <= 1'b0;
    end else begin
      if (full_closed) begin
        cur_pos <= scnt_reg;
      end else begin
        cur_pos <= {mt_reg, enc_single_turn};
      end
      scale_pos <= mon_en ? scnt_reg : 32'h0;
      mt_valid <= (eff != ENC_INC) && (eff != ENC_SINGLE);
      scale_mon_en <= mon_en;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_inc_no_abs: assert property (
    @(posedge clk) disable iff (!arst_n)
    (err_o.abs_down || err_o.abs_ospd) |-> $past(eff) != ENC_INC)
    else $error("Absolute error reported in incremental mode.");
  a_single_mt_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    eff == ENC_SINGLE |=> mt_reg == 16'h0000)
    else $error("Multi-turn count moved in single-turn mode.");
  a_cont_wrap_top: assert property (
    @(posedge clk) disable iff (!arst_n)
    (eff == ENC_CONT && enc_turn_up && !enc_turn_down &&
     mt_reg == mt_limit_reg) |=> mt_reg == 16'h0000)
    else $error("Multi-turn did not wrap at the limit.");
  a_fc_forces_inc: assert property (
    @(posedge clk) disable iff (!arst_n)
    full_closed |=> !mt_valid)
    else $error("Full-closed control left multi-turn valid.");
  a_noovf_quiet: assert property (
    @(posedge clk) disable iff (!arst_n)
    err_o.abs_over |-> $past(eff) == ENC_ABS)
    else $error("Counter overflow reported outside absolute mode.");
  // The release edge still clocks the reset branch, so it starts no try.
  a_cur_pos_abs: assert property (
    @(posedge clk) disable iff (!arst_n)
    (arst_n && !full_closed) ##1 1 |-> cur_pos == {$past(mt_reg),
                                                  $past(enc_single_turn)})
    else $error("Current position does not carry absolute data.");
  a_cmd_err_cycle: assert property (
    @(posedge clk) disable iff (!arst_n)
    (comm_ext_reg[EXT_MON_BIT] && !full_closed &&
     comm_cycle_us == COMM_CYC_125_US) |=> err_o.cmd ##1 status_reg[3])
    else $error("Command error missing for a short cycle.");
  a_z_skip: assert property (
    @(posedge clk) disable iff (!arst_n)
    err_o.scale_break |-> $past(index_dis_reg[0]) == 1'b0)
    else $error("Index loss reported while detection disabled.");
  a_mon_gate: assert property (
    @(posedge clk) disable iff (!arst_n)
    !mon_en |=> scale_pos == 32'h0 && !err_o.scale_link)
    else $error("Scale data shown with monitoring disabled.");
  a_conn_mismatch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (mon_en && scale_present && scale_kind_id != scale_type_reg[2:0])
    |=> err_o.scale_conn)
    else $error("Scale type mismatch not reported.");

endmodule : aps_setup
`default_nettype wire

/* File: testbench/aps_host_model.sv */
// Host motion controller model on the far side of the cyclic fieldbus.
`timescale 1ns/100ps
`default_nettype none
module aps_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Fieldbus response from the drive.
  input wire logic [31:0] cur_pos,
  input wire logic mt_valid,
  // Position the controller works with.
  output logic [31:0] host_pos
);
  // The controller drops the multi-turn half whenever the drive flags it
  // as meaningless, so a stale count can never leak into its coordinates.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_pos <= 32'h0;
    end else begin
      host_pos <= mt_valid ? cur_pos
                           : {16'h0000, cur_pos[15:0]};
    end
  end
endmodule : aps_host_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking testbench of the absolute position setup block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import aps_pkg::*;
  logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cur_pos, scale_pos, host_pos, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] enc_single_turn, comm_cycle_us;
  logic enc_turn_up, enc_turn_down, enc_batt_fail_pin, enc_overspeed_pin;
  logic scale_cnt_up, scale_cnt_dn, scale_present, scale_z_lost_pin;
  logic scale_link_fault_pin, full_closed, mt_valid, scale_mon_en, irq;
  logic [2:0] scale_kind_id;
  aps_err_t err_o;
  int n_errors, checked;

  // ----------------------------------------------------------------
  // Design, host model and clock
  // ----------------------------------------------------------------
  aps_setup aps_setup_inst (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .enc_single_turn, .enc_turn_up,
    .enc_turn_down, .enc_batt_fail_pin, .enc_overspeed_pin, .scale_cnt_up,
    .scale_cnt_dn, .scale_present, .scale_kind_id, .scale_z_lost_pin,
    .scale_link_fault_pin, .full_closed, .comm_cycle_us, .cur_pos,
    .scale_pos, .mt_valid, .scale_mon_en, .err_o, .irq);
  aps_host_model aps_host_model_inst (.clk, .arst_n, .cur_pos, .mt_valid,
    .host_pos);

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // Address and data are released each at its own take; only the
  // watchdog ends a wait for an answer that never comes.
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read data and response are taken at the edge that sees rvalid.
  task rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Pins pass two sync stages, so six cycles leave ample settling room.
  task st(input logic [31:0] e);
    repeat (6) @(posedge clk);
    rd(OFS_IRQ_STATUS);
    chk("status", e, rdat);
  endtask : st

  // One-cycle pulse on {scale_cnt_up, enc_turn_down, enc_turn_up}.
  task pulse(input logic [2:0] s);
    @(posedge clk);
    {scale_cnt_up, enc_turn_down, enc_turn_up} <= s;
    @(posedge clk);
    {scale_cnt_up, enc_turn_down, enc_turn_up} <= 3'h0;
  endtask : pulse

  task end_of_test;
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // The whole run is a few hundred cycles; this cuts off a hang.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {enc_turn_up, enc_turn_down, scale_cnt_up, scale_cnt_dn} = 4'h0;
    {enc_batt_fail_pin, enc_overspeed_pin, scale_z_lost_pin} = 3'h0;
    {scale_link_fault_pin, full_closed, scale_present} = 3'h0;
    enc_single_turn = 16'h1234;
    comm_cycle_us = 16'h03E8;
    scale_kind_id = 3'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_ENC_USAGE);
    chk("usage reset", 32'h1, rdat);
    rd(OFS_MT_LIMIT);
    chk("limit reset", 32'hFFFF, rdat);
    rd(8'h30);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // Incremental use hides the absolute errors; absolute use shows them.
    wr(OFS_ENC_USAGE, 32'h1);
    {enc_batt_fail_pin, enc_overspeed_pin} <= 2'h3;
    st(32'h0);
    wr(OFS_IRQ_ENABLE, 32'h5);
    wr(OFS_ENC_USAGE, 32'h0);
    st(32'h5);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    {enc_batt_fail_pin, enc_overspeed_pin} <= 2'h0;
    repeat (4) @(posedge clk);
    wr(OFS_IRQ_CLEAR, 32'h7F);
    st(32'h0);
    // Multi-turn wrap raises an error in mode 0 but not in mode 2.
    pulse(3'h2);
    st(32'h2);
    rd(OFS_MTURN);
    chk("mturn", 32'hFFFF, rdat);
    chk("host pos", 32'hFFFF1234, host_pos);
    wr(OFS_IRQ_CLEAR, 32'h7F);
    wr(OFS_ENC_USAGE, 32'h2);
    pulse(3'h1);
    st(32'h0);
    // Single-turn use keeps the multi-turn count out of the position.
    wr(OFS_ENC_USAGE, 32'h3);
    pulse(3'h1);
    rd(OFS_MTURN);
    chk("single mturn", 32'h0, rdat);
    chk("single pos", 32'h00001234, host_pos);
    // Continuous rotation wraps at the settable limit without an error.
    wr(OFS_ENC_USAGE, 32'h4);
    wr(OFS_MT_LIMIT, 32'h1);
    pulse(3'h1);
    pulse(3'h1);
    rd(OFS_MTURN);
    chk("cont mturn", 32'h0, rdat);
    st(32'h0);
    // Every legal usage value shows as the effective mode; 5 is ignored.
    for (int m = 0; m < 5; m++) begin
      wr(OFS_ENC_USAGE, m);
      rd(OFS_STATE);
      chk("mode", m, rdat);
    end
    wr(OFS_ENC_USAGE, 32'h5);
    rd(OFS_ENC_USAGE);
    chk("usage", 32'h4, rdat);
    full_closed <= 1'b1;
    wr(OFS_ENC_USAGE, 32'h0);
    rd(OFS_STATE);
    chk("full closed", 32'h19, rdat);
    full_closed <= 1'b0;
    // Semi-closed monitoring with inverted scale direction.
    wr(OFS_COMM_EXT, 32'h10);
    wr(OFS_SCALE_DIR, 32'h1);
    pulse(3'h4);
    pulse(3'h4);
    st(32'h0);
    chk("mon en", 32'h1, {31'h0, scale_mon_en});
    rd(OFS_SCALE_POS);
    chk("scale pos", 32'hFFFFFFFE, rdat);
    chk("scale pos out", 32'hFFFFFFFE, scale_pos);
    // Both short fieldbus cycles forbid semi-closed monitoring.
    for (int i = 0; i < 2; i++) begin
      comm_cycle_us <= i ? COMM_CYC_125_US : COMM_CYC_250_US;
      st(32'h8);
      chk("cmd err", 32'h8, {25'h0, err_o});
      comm_cycle_us <= 16'h03E8;
      repeat (2) @(posedge clk);
      wr(OFS_IRQ_CLEAR, 32'h7F);
    end
    // A scale of another type than selected is refused.
    scale_present <= 1'b1;
    scale_kind_id <= 3'h1;
    wr(OFS_SCALE_TYPE, 32'h2);
    st(32'h10);
    scale_kind_id <= 3'h2;
    repeat (2) @(posedge clk);
    wr(OFS_IRQ_CLEAR, 32'h7F);
    st(32'h0);
    // Index loss on a quadrature scale is seen only while enabled.
    scale_kind_id <= 3'h0;
    wr(OFS_SCALE_TYPE, 32'h0);
    wr(OFS_INDEX_DIS, 32'h0);
    // Type and kind disagreed during the swap; both match again now.
    wr(OFS_IRQ_CLEAR, 32'h7F);
    scale_z_lost_pin <= 1'b1;
    st(32'h20);
    wr(OFS_INDEX_DIS, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h7F);
    st(32'h0);
    // A broken scale link is flagged while monitoring is on.
    scale_link_fault_pin <= 1'b1;
    st(32'h40);
    // The multi-turn count does not survive a control power cycle.
    pulse(3'h1);
    rd(OFS_MTURN);
    chk("mturn up", 32'h1, rdat);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_MTURN);
    chk("mturn power", 32'h0, rdat);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
